// *** cad_defines.vh ***
/*
 Constants for the core ALU operand datapath: register offsets, command
 fields, operation codes, addressing modes, status bit positions, resets.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH
// Register byte offsets
`define CAD_OFS_CMD 8'h00
`define CAD_OFS_CMD2 8'h04
`define CAD_OFS_STAT 8'h08
`define CAD_OFS_ACCA_LO 8'h10
`define CAD_OFS_ACCA_HI 8'h14
`define CAD_OFS_ACCB_LO 8'h18
`define CAD_OFS_ACCB_HI 8'h1c
`define CAD_OFS_MADR 8'h20
`define CAD_OFS_MDAT 8'h24
`define CAD_WIN_DEFAULT_FILE_OPERAND_REGISTER 2'h1
// Command word fields
`define CAD_CMD_OP 3:0
`define CAD_CMD_CIN 4
`define CAD_CMD_TOW 5
`define CAD_CMD_ACC 6
`define CAD_CMD_SMODE 9:7
`define CAD_CMD_DMODE 12:10
`define CAD_CMD_SREG 16:13
`define CAD_CMD_DREG 20:17
`define CAD_CMD_BREG 24:21
// Second command word fields
`define CAD_CMD2_LIT 9:0
`define CAD_CMD2_PAIR 12:10
`define CAD_CMD2_XSEL 14:13
`define CAD_CMD2_XMOD 17:15
`define CAD_CMD2_XDST 19:18
`define CAD_CMD2_YSEL 21:20
`define CAD_CMD2_YMOD 24:22
`define CAD_CMD2_YDST 26:25
// Operation codes
`define CAD_OP_ADD_W 4'h0
`define CAD_OP_ADD_L5 4'h1
`define CAD_OP_ADD_L10 4'h2
`define CAD_OP_ADD_F 4'h3
`define CAD_OP_ASR_F 4'h4
`define CAD_OP_ASR_W 4'h5
`define CAD_OP_ASR_WN 4'h6
`define CAD_OP_ASR_L5 4'h7
`define CAD_OP_ADD_ACC 4'h8
`define CAD_OP_ADD_WSO 4'h9
`define CAD_OP_MAC 4'ha
`define CAD_OP_SQR 4'hb
`define CAD_OP_DIV 4'hc
// Addressing modes
`define CAD_AM_DIR 3'h0
`define CAD_AM_IND 3'h1
`define CAD_AM_POSTINC 3'h2
`define CAD_AM_POSTDEC 3'h3
`define CAD_AM_PREINC 3'h4
`define CAD_AM_PREDEC 3'h5
`define CAD_AM_BASE 3'h6
// Prefetch pointer selections
`define CAD_PF_NONE 2'h0
`define CAD_PF_PTR_A 2'h1
`define CAD_PF_PTR_B 2'h2
`define CAD_PF_OFS 2'h3
`define CAD_PF_MOD_BAD 3'h4
`define CAD_PAIR_LAST 3'h5
// Fixed working register numbers
`define CAD_W_DEF 4'h0
`define CAD_W_REM 4'h1
`define CAD_W_X_A 4'h8
`define CAD_W_X_B 4'h9
`define CAD_W_Y_A 4'ha
`define CAD_W_Y_B 4'hb
`define CAD_W_PF_OFS 4'hc
`define CAD_W_FACT_HI 2'h1
`define CAD_PTR_STEP 16'h0002
// Status bit positions
`define CAD_ST_C 0
`define CAD_ST_Z 1
`define CAD_ST_OV 2
`define CAD_ST_N 3
`define CAD_ST_DC 8
`define CAD_ST_SB 12
`define CAD_ST_SA 13
`define CAD_ST_OB 14
`define CAD_ST_OA 15
`define CAD_ST_BUSY 16
`define CAD_ST_ILL 17
`define CAD_ST_REJ 18
// Reset values and sizes
`define CAD_RST_WORD 16'h0000
`define CAD_RST_CMD 32'h0000_0000
`define CAD_RST_ACC 40'h00_0000_0000
`define CAD_MEM_AW 6
`define CAD_MEM_DEPTH 64
`endif

// *** cad_data_ram.v ***
/*
 Small single-port data memory for the datapath's data spaces.
 Assumes one clock; read data appears one cycle after the address.
*/
`timescale 1ns/1ps
`include "cad_defines.vh"
module cad_data_ram (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Access port
	input wire [`CAD_MEM_AW-1:0] addr_i,
	input wire we_i,
	input wire [15:0] wdata_i,
	output reg [15:0] rdata_o
);
	reg [15:0] mem_q [0:`CAD_MEM_DEPTH-1];

	always @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem_q[addr_i] <= wdata_i;
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdata_o <= `CAD_RST_WORD;
		end
		else
		begin
			rdata_o <= mem_q[addr_i];
		end
	end
endmodule // cad_data_ram

// *** cad_alu_datapath.v ***
/*
 Operand selection and arithmetic datapath with a Wishbone register port.
 Assumes a classic Wishbone master on clk_i and a synchronous reset.
*/
// Added by the designer: the Wishbone slave port and the register offsets.
// What this block does
// - Sixteen working registers, each usable as source, destination or base.
// - File-register operations use working register zero as default operand.
// - Operands support direct, indirect, post and pre increment or decrement.
// - Accumulator operand adds pointer-plus-base mode and refuses plain indirect.
// - X prefetch via W8 or W9, step 2/4/6, W9+W12, or none.
// - Y prefetch via W10 or W11, step 2/4/6, W11+W12, or none.
// - Prefetched words land in W4 to W7, chosen separately per space.
// - Multiply factors come from one of six distinct W4..W7 pairs.
// - Square multiplies one of W4 to W7 by itself only.
// - Divide reads dividend and divisor directly from two working registers.
// - Signed word with signed shift literal adds into accumulator, acc flags.
// - Add with or without carry; updates C, DC, N, OV, Z.
// - Single-bit arithmetic right shift keeps sign; updates C, N, OV, Z.
// - Multi-bit arithmetic right shift writes direct register; updates N, Z.
`timescale 1ns/1ps
`include "cad_defines.vh"
module cad_alu_datapath (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Status
	output reg busy_o
);
	localparam S_IDLE = 3'h0;
	localparam S_SRC = 3'h1;
	localparam S_EXEC = 3'h2;
	localparam S_XF = 3'h3;
	localparam S_XW = 3'h4;
	localparam S_YW = 3'h5;

	reg [15:0] w_q [0:15];
	reg [31:0] cmd_q;
	reg [31:0] cmd2_q;
	reg [39:0] acca_q;
	reg [39:0] accb_q;
	reg [15:0] madr_q;
	reg [2:0] st_q;
	reg src_mem_q;
	reg c_q, z_q, ov_q, n_q, dc_q, oa_q, ob_q, sa_q, sb_q, ill_q, rej_q;
	integer i;

	function [15:0] am_ea;
		input [2:0] m;
		input [15:0] v;
		input [15:0] b;
		begin
			case (m)
				`CAD_AM_PREINC: am_ea = v + `CAD_PTR_STEP;
				`CAD_AM_PREDEC: am_ea = v - `CAD_PTR_STEP;
				`CAD_AM_BASE: am_ea = v + b;
				default: am_ea = v;
			endcase
		end
	endfunction

	function [15:0] am_nxt;
		input [2:0] m;
		input [15:0] v;
		begin
			case (m)
				`CAD_AM_POSTINC, `CAD_AM_PREINC: am_nxt = v + `CAD_PTR_STEP;
				`CAD_AM_POSTDEC, `CAD_AM_PREDEC: am_nxt = v - `CAD_PTR_STEP;
				default: am_nxt = v;
			endcase
		end
	endfunction

	// Command fields
	wire [3:0] op = cmd_q[`CAD_CMD_OP];
	wire cin = cmd_q[`CAD_CMD_CIN];
	wire towreg = cmd_q[`CAD_CMD_TOW];
	wire acc_sel = cmd_q[`CAD_CMD_ACC];
	wire [2:0] smode = cmd_q[`CAD_CMD_SMODE];
	wire [2:0] dmode = cmd_q[`CAD_CMD_DMODE];
	wire [3:0] sreg = cmd_q[`CAD_CMD_SREG];
	wire [3:0] dreg = cmd_q[`CAD_CMD_DREG];
	wire [3:0] breg = cmd_q[`CAD_CMD_BREG];
	wire [9:0] lit = cmd2_q[`CAD_CMD2_LIT];
	wire [2:0] pair = cmd2_q[`CAD_CMD2_PAIR];
	wire [1:0] xsel = cmd2_q[`CAD_CMD2_XSEL];
	wire [2:0] xmod = cmd2_q[`CAD_CMD2_XMOD];
	wire [1:0] xdst = cmd2_q[`CAD_CMD2_XDST];
	wire [1:0] ysel = cmd2_q[`CAD_CMD2_YSEL];
	wire [2:0] ymod = cmd2_q[`CAD_CMD2_YMOD];
	wire [1:0] ydst = cmd2_q[`CAD_CMD2_YDST];

	// Operation classes
	wire file_op = (op == `CAD_OP_ADD_F) | (op == `CAD_OP_ASR_F);
	wire ws_op = (op == `CAD_OP_ADD_W) | (op == `CAD_OP_ASR_W) |
		(op == `CAD_OP_ADD_WSO);
	wire src_ind = ws_op & (smode != `CAD_AM_DIR);
	wire add_op = (op == `CAD_OP_ADD_W) | (op == `CAD_OP_ADD_L5) |
		(op == `CAD_OP_ADD_L10) | (op == `CAD_OP_ADD_F);
	wire asr1_op = (op == `CAD_OP_ASR_F) | (op == `CAD_OP_ASR_W);
	wire asrn_op = (op == `CAD_OP_ASR_WN) | (op == `CAD_OP_ASR_L5);
	wire mul_op = (op == `CAD_OP_MAC) | (op == `CAD_OP_SQR);
	wire acc_op = mul_op | (op == `CAD_OP_ADD_ACC) |
		(op == `CAD_OP_ADD_WSO);
	wire dst_mem = (file_op & ~towreg) | (dmode != `CAD_AM_DIR &
		((op == `CAD_OP_ADD_W) | (op == `CAD_OP_ADD_L5) |
		(op == `CAD_OP_ASR_W)));
	wire ill_cmd = (op > `CAD_OP_DIV) | (dmode >= `CAD_AM_BASE) |
		(smode > `CAD_AM_BASE) |
		(smode == `CAD_AM_BASE & op != `CAD_OP_ADD_WSO) |
		(smode == `CAD_AM_IND & op == `CAD_OP_ADD_WSO) |
		(op == `CAD_OP_MAC & pair > `CAD_PAIR_LAST) |
		(op == `CAD_OP_SQR & pair[2]) |
		(mul_op & (xmod == `CAD_PF_MOD_BAD | ymod == `CAD_PF_MOD_BAD));

	// Operand values and effective addresses
	wire [15:0] sreg_v = w_q[sreg];
	wire [15:0] dreg_v = w_q[dreg];
	wire [15:0] breg_v = w_q[breg];
	wire [15:0] s_ea = am_ea(smode, sreg_v, breg_v);
	wire [15:0] s_nxt = am_nxt(smode, sreg_v);
	wire [15:0] d_ea = am_ea(dmode, dreg_v, breg_v);
	wire [15:0] d_nxt = am_nxt(dmode, dreg_v);
	wire [15:0] m_rd;
	wire [15:0] opnd = src_mem_q ? m_rd : sreg_v;

	// Prefetch pointers
	wire [3:0] x_ptr = (xsel == `CAD_PF_PTR_A) ? `CAD_W_X_A : `CAD_W_X_B;
	wire [3:0] y_ptr = (ysel == `CAD_PF_PTR_A) ? `CAD_W_Y_A : `CAD_W_Y_B;
	wire [15:0] x_v = w_q[x_ptr];
	wire [15:0] y_v = w_q[y_ptr];
	wire [15:0] x_ea = (xsel == `CAD_PF_OFS) ? x_v + w_q[`CAD_W_PF_OFS] :
		x_v;
	wire [15:0] y_ea = (ysel == `CAD_PF_OFS) ? y_v + w_q[`CAD_W_PF_OFS] :
		y_v;
	wire [15:0] x_nxt = x_v + {{12{xmod[2]}}, xmod, 1'b0};
	wire [15:0] y_nxt = y_v + {{12{ymod[2]}}, ymod, 1'b0};

	// Adder
	reg [15:0] add_a;
	reg [15:0] add_b;
	always @*
	begin
		add_a = breg_v;
		add_b = opnd;
		if (op == `CAD_OP_ADD_L5)
		begin
			add_b = {11'h000, lit[4:0]};
		end
		else if (op == `CAD_OP_ADD_L10)
		begin
			add_a = dreg_v;
			add_b = {6'h00, lit};
		end
		else if (op == `CAD_OP_ADD_F)
		begin
			add_a = opnd;
			add_b = w_q[`CAD_W_DEF];
		end
	end
	wire cin_v = cin & c_q;
	wire [16:0] sum = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, cin_v};
	wire [4:0] hsum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} +
		{4'h0, cin_v};
	wire sum_ov = (add_a[15] == add_b[15]) & (sum[15] != add_a[15]);

	// Shifters
	wire [15:0] asr1 = {opnd[15], opnd[15:1]};
	wire [4:0] asr_amt = (op == `CAD_OP_ASR_WN) ? {1'b0, sreg_v[3:0]} :
		lit[4:0];
	wire [15:0] asrn = $signed(breg_v) >>> asr_amt;
	wire [15:0] res = asr1_op ? asr1 : (asrn_op ? asrn : sum[15:0]);

	// Multiplier factors
	reg [1:0] fm_off;
	reg [1:0] fn_off;
	always @*
	begin
		fm_off = pair[1:0];
		fn_off = pair[1:0];
		if (op == `CAD_OP_MAC)
		begin
			case (pair)
				3'h0: {fm_off, fn_off} = 4'h1;
				3'h1: {fm_off, fn_off} = 4'h2;
				3'h2: {fm_off, fn_off} = 4'h3;
				3'h3: {fm_off, fn_off} = 4'h6;
				3'h4: {fm_off, fn_off} = 4'h7;
				default: {fm_off, fn_off} = 4'hb;
			endcase
		end
	end
	wire [15:0] fm_v = w_q[{`CAD_W_FACT_HI, fm_off}];
	wire [15:0] fn_v = w_q[{`CAD_W_FACT_HI, fn_off}];
	wire [31:0] prod = $signed(fm_v) * $signed(fn_v);

	// Divider on direct registers only
	wire [15:0] quo = $signed(sreg_v) / $signed(breg_v);
	wire [15:0] rem = $signed(sreg_v) % $signed(breg_v);

	// Accumulator adder
	wire [39:0] acc_cur = acc_sel ? accb_q : acca_q;
	wire [39:0] wso40 = {{8{opnd[15]}}, opnd, 16'h0000};
	wire [3:0] sl_neg = 4'h0 - lit[3:0];
	reg [39:0] addend;
	always @*
	begin
		addend = acc_sel ? acca_q : accb_q;
		if (op == `CAD_OP_ADD_WSO)
		begin
			if (lit[3])
			begin
				addend = wso40 << sl_neg;
			end
			else
			begin
				addend = $signed(wso40) >>> lit[2:0];
			end
		end
		else if (mul_op)
		begin
			addend = {{8{prod[31]}}, prod};
		end
	end
	wire [40:0] acc_sum = {acc_cur[39], acc_cur} + {addend[39], addend};
	wire [39:0] acc_new = acc_sum[39:0];
	wire acc_sat = acc_sum[40] ^ acc_sum[39];
	wire acc_grd = ~((&acc_new[39:31]) | ~(|acc_new[39:31]));

	// Bus decode
	wire [7:0] ofs = {wb_adr_i[7:2], 2'b00};
	wire is_w = (wb_adr_i[7:6] == `CAD_WIN_DEFAULT_FILE_OPERAND_REGISTER);
	wire [3:0] widx = wb_adr_i[5:2];
	wire bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire idle = (st_q == S_IDLE);
	wire sw_wr = bus_go & wb_we_i & idle;

	// Data memory port
	reg [`CAD_MEM_AW-1:0] m_addr;
	reg m_we;
	reg [15:0] m_wd;
	always @*
	begin
		m_addr = madr_q[`CAD_MEM_AW:1];
		m_we = 1'b0;
		m_wd = wb_dat_i[15:0];
		if (st_q == S_SRC)
		begin
			m_addr = file_op ? lit[`CAD_MEM_AW:1] : s_ea[`CAD_MEM_AW:1];
		end
		else if (st_q == S_EXEC)
		begin
			m_addr = file_op ? lit[`CAD_MEM_AW:1] : d_ea[`CAD_MEM_AW:1];
			m_we = dst_mem;
			m_wd = res;
		end
		else if (st_q == S_XF)
		begin
			m_addr = x_ea[`CAD_MEM_AW:1];
		end
		else if (st_q == S_XW)
		begin
			m_addr = y_ea[`CAD_MEM_AW:1];
		end
		else if (sw_wr & (ofs == `CAD_OFS_MDAT))
		begin
			m_we = 1'b1;
		end
	end

	cad_data_ram u_ram (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_i(m_addr),
		.we_i(m_we),
		.wdata_i(m_wd),
		.rdata_o(m_rd)
	);

	// Status and read mux
	reg [31:0] stat_w;
	reg [31:0] rd_w;
	always @*
	begin
		stat_w = 32'h0000_0000;
		stat_w[`CAD_ST_C] = c_q;
		stat_w[`CAD_ST_Z] = z_q;
		stat_w[`CAD_ST_OV] = ov_q;
		stat_w[`CAD_ST_N] = n_q;
		stat_w[`CAD_ST_DC] = dc_q;
		stat_w[`CAD_ST_SB] = sb_q;
		stat_w[`CAD_ST_SA] = sa_q;
		stat_w[`CAD_ST_OB] = ob_q;
		stat_w[`CAD_ST_OA] = oa_q;
		stat_w[`CAD_ST_BUSY] = busy_o;
		stat_w[`CAD_ST_ILL] = ill_q;
		stat_w[`CAD_ST_REJ] = rej_q;
		if (is_w)
			rd_w = {16'h0000, w_q[widx]};
		else if (ofs == `CAD_OFS_CMD)
			rd_w = cmd_q;
		else if (ofs == `CAD_OFS_CMD2)
			rd_w = cmd2_q;
		else if (ofs == `CAD_OFS_STAT)
			rd_w = stat_w;
		else if (ofs == `CAD_OFS_ACCA_LO)
			rd_w = acca_q[31:0];
		else if (ofs == `CAD_OFS_ACCA_HI)
			rd_w = {24'h000000, acca_q[39:32]};
		else if (ofs == `CAD_OFS_ACCB_LO)
			rd_w = accb_q[31:0];
		else if (ofs == `CAD_OFS_ACCB_HI)
			rd_w = {24'h000000, accb_q[39:32]};
		else if (ofs == `CAD_OFS_MADR)
			rd_w = {16'h0000, madr_q};
		else if (ofs == `CAD_OFS_MDAT)
			rd_w = {16'h0000, m_rd};
		else
			rd_w = 32'h0000_0000;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (i = 0; i < 16; i = i + 1)
				w_q[i] <= `CAD_RST_WORD;
			cmd_q <= `CAD_RST_CMD;
			cmd2_q <= `CAD_RST_CMD;
			acca_q <= `CAD_RST_ACC;
			accb_q <= `CAD_RST_ACC;
			madr_q <= `CAD_RST_WORD;
			st_q <= S_IDLE;
			src_mem_q <= 1'b0;
			{c_q, z_q, ov_q, n_q, dc_q} <= 5'h00;
			{oa_q, ob_q, sa_q, sb_q, ill_q, rej_q} <= 6'h00;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			busy_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= bus_go;
			if (bus_go)
				wb_dat_o <= rd_w;
			if (bus_go & wb_we_i & ~idle & (ofs == `CAD_OFS_CMD))
				rej_q <= 1'b1;
			if (sw_wr)
			begin
				if (is_w)
				begin
					if (wb_sel_i[0])
						w_q[widx][7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						w_q[widx][15:8] <= wb_dat_i[15:8];
				end
				else if (ofs == `CAD_OFS_CMD)
				begin
					cmd_q <= wb_dat_i;
					st_q <= S_SRC;
					busy_o <= 1'b1;
				end
				else if (ofs == `CAD_OFS_CMD2)
					cmd2_q <= wb_dat_i;
				else if (ofs == `CAD_OFS_STAT)
				begin
					c_q <= wb_dat_i[`CAD_ST_C];
					z_q <= wb_dat_i[`CAD_ST_Z];
					ov_q <= wb_dat_i[`CAD_ST_OV];
					n_q <= wb_dat_i[`CAD_ST_N];
					dc_q <= wb_dat_i[`CAD_ST_DC];
					sb_q <= wb_dat_i[`CAD_ST_SB];
					sa_q <= wb_dat_i[`CAD_ST_SA];
					ob_q <= wb_dat_i[`CAD_ST_OB];
					oa_q <= wb_dat_i[`CAD_ST_OA];
					if (wb_dat_i[`CAD_ST_ILL])
						ill_q <= 1'b0;
					if (wb_dat_i[`CAD_ST_REJ])
						rej_q <= 1'b0;
				end
				else if (ofs == `CAD_OFS_ACCA_LO)
					acca_q[31:0] <= wb_dat_i;
				else if (ofs == `CAD_OFS_ACCA_HI)
					acca_q[39:32] <= wb_dat_i[7:0];
				else if (ofs == `CAD_OFS_ACCB_LO)
					accb_q[31:0] <= wb_dat_i;
				else if (ofs == `CAD_OFS_ACCB_HI)
					accb_q[39:32] <= wb_dat_i[7:0];
				else if (ofs == `CAD_OFS_MADR)
					madr_q <= wb_dat_i[15:0];
			end
			case (st_q)
				S_SRC:
				begin
					if (ill_cmd)
					begin
						ill_q <= 1'b1;
						st_q <= S_IDLE;
						busy_o <= 1'b0;
					end
					else
					begin
						src_mem_q <= file_op | src_ind;
						if (src_ind)
							w_q[sreg] <= s_nxt;
						st_q <= S_EXEC;
					end
				end
				S_EXEC:
				begin
					st_q <= mul_op ? S_XF : S_IDLE;
					busy_o <= mul_op;
					if (add_op | asr1_op)
					begin
						if (file_op & towreg)
							w_q[`CAD_W_DEF] <= res;
						else if (~file_op & dmode == `CAD_AM_DIR)
							w_q[dreg] <= res;
						else if (~file_op)
							w_q[dreg] <= d_nxt;
					end
					if (asrn_op)
						w_q[dreg] <= res;
					if ((op == `CAD_OP_DIV) & (breg_v != 16'h0000))
					begin
						w_q[`CAD_W_DEF] <= quo;
						w_q[`CAD_W_REM] <= rem;
					end
					if (add_op)
					begin
						c_q <= sum[16];
						dc_q <= hsum[4];
						n_q <= sum[15];
						ov_q <= sum_ov;
						z_q <= (sum[15:0] == 16'h0000) & (z_q | ~cin);
					end
					else if (asr1_op)
					begin
						c_q <= opnd[0];
						n_q <= res[15];
						ov_q <= 1'b0;
						z_q <= (res == 16'h0000);
					end
					else if (asrn_op)
					begin
						n_q <= res[15];
						z_q <= (res == 16'h0000);
					end
					if (acc_op & ~acc_sel)
					begin
						acca_q <= acc_new;
						oa_q <= acc_grd;
						sa_q <= sa_q | acc_sat;
					end
					else if (acc_op)
					begin
						accb_q <= acc_new;
						ob_q <= acc_grd;
						sb_q <= sb_q | acc_sat;
					end
				end
				S_XF:
				begin
					if (xsel != `CAD_PF_NONE & xsel != `CAD_PF_OFS)
						w_q[x_ptr] <= x_nxt;
					st_q <= S_XW;
				end
				S_XW:
				begin
					if (xsel != `CAD_PF_NONE)
						w_q[{`CAD_W_FACT_HI, xdst}] <= m_rd;
					if (ysel != `CAD_PF_NONE & ysel != `CAD_PF_OFS)
						w_q[y_ptr] <= y_nxt;
					st_q <= S_YW;
				end
				S_YW:
				begin
					if (ysel != `CAD_PF_NONE)
						w_q[{`CAD_W_FACT_HI, ydst}] <= m_rd;
					st_q <= S_IDLE;
					busy_o <= 1'b0;
				end
				default:
				begin
				end
			endcase
		end
	end
endmodule // cad_alu_datapath

// *** cad_alu_props.sv ***
/*
 Bus timing and command timing assertions for the ALU datapath.
 Assumes a bind onto cad_alu_datapath, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module cad_alu_props (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// Status
	input wire busy_o
);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire hole = wb_adr_i[7:2] == 6'h03 || wb_adr_i[7] ||
		(wb_adr_i >= 8'h28 && wb_adr_i < 8'h40);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_on_time: assert property (take |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property ($rose(wb_ack_o) |->
		$past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_unmapped_zero: assert property (take && !wb_we_i && hole |=>
		wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_busy_start: assert property (take && wb_we_i && wb_adr_i[7:2] == 6'h00
		&& !busy_o |=> busy_o) else $error("command did not start");
	a_busy_ends: assert property ($rose(busy_o) |-> ##[1:5] !busy_o)
		else $error("command runs too long");
	a_busy_status: assert property (take && !wb_we_i && wb_adr_i == 8'h08
		|=> wb_dat_o[16] == $past(busy_o)) else $error("busy bit mismatch");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !wb_ack_o && !busy_o) else $error("outputs live in reset");
endmodule // cad_alu_props

bind cad_alu_datapath cad_alu_props i_cad_alu_props (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.busy_o(busy_o));

// *** cad_wb_host.sv ***
/*
 Classic Wishbone master standing for the decoder side.
 Assumes one clock; requests held until ack is sampled high.
*/
`timescale 1ns/1ps
module cad_wb_host (
	// Clock
	input wire clk_i,
	// Request
	output reg cyc_o = 1'b0,
	output reg stb_o = 1'b0,
	output reg we_o = 1'b0,
	output reg [7:0] adr_o = 8'h00,
	output reg [3:0] sel_o = 4'hf,
	output reg [31:0] dat_o = 32'h0,
	// Answer
	input wire [31:0] dat_i,
	input wire ack_i
);
	task xfer(input w, input [7:0] a, input [31:0] d, input [3:0] s,
		output [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		adr_o <= ~a;
		sel_o <= 4'hf;
		dat_o <= ~d;
	endtask
endmodule // cad_wb_host

// *** tb_top.sv ***
/*
 Self-checking bench for the ALU datapath.
 Assumes the datapath, its checker and the bus host model.
*/
`timescale 1ns/1ps
`include "cad_defines.vh"
module tb_top;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	wire cyc, stb, we, ack, busy;
	wire [7:0] adr;
	wire [3:0] sel;
	wire [31:0] mdat, sdat;
	int n_errors = 0;
	int cmp_count = 0;
	reg [15:0] w [0:15];
	reg [15:0] lf = 16'h0014;
	reg [31:0] q, st, pr, cmd, cmd2;
	reg [15:0] a, b;
	reg [3:0] sr, dr, br;
	reg [2:0] p;
	reg [7:0] pt;
	reg signed [39:0] ep;
	localparam [47:0] pair_tab = 48'h45_46_47_56_57_67;
	cad_alu_datapath i_cad_alu_datapath (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(mdat), .wb_dat_o(sdat), .wb_ack_o(ack),
		.busy_o(busy));
	cad_wb_host i_cad_wb_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(mdat), .dat_i(sdat),
		.ack_i(ack));
	function [15:0] nxt(input [15:0] v);
		nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Result in 31:16, flags at their status positions
	function [31:0] fadd(input [15:0] x, input [15:0] y, input c, input zs);
		reg [16:0] s;
		reg [15:0] o;
		s = x + y + c;
		o = s[15:0];
		fadd = {o, 7'h0, (x[3:0] + y[3:0] + c) > 15, 4'h0, o[15],
			(x[15] == y[15]) && (o[15] != x[15]), (o == 0) && zs, s[16]};
	endfunction
	task wrb(input [7:0] ad, input [31:0] d, input [3:0] s);
		reg [31:0] x;
		i_cad_wb_host.xfer(1'b1, ad, d, s, x);
	endtask
	task wr(input [7:0] ad, input [31:0] d);
		wrb(ad, d, 4'hf);
	endtask
	task rd(input [7:0] ad, output [31:0] d);
		i_cad_wb_host.xfer(1'b0, ad, 32'h0, 4'hf, d);
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task run(input [31:0] c2, input [31:0] c);
		wr(8'h04, c2);
		wr(8'h00, c);
		@(negedge clk_i);
		chk({31'h0, busy}, 32'h1);
		do rd(8'h08, st); while (st[16] !== 1'b0);
	endtask
	task chkw(input [3:0] n, input [15:0] v);
		rd({2'h1, n, 2'h0}, q);
		chk(q, {16'h0, v});
	endtask
	task setw(input [3:0] n, input [15:0] v);
		w[n] = v;
		wr({2'h1, n, 2'h0}, {16'h0, v});
	endtask
	task tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
		forever #2.5 clk_i = ~clk_i;
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		tally_and_finish;
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h08, q);
		chk(q, 32'h0);
		rd(8'h30, q);
		chk(q, 32'h0);
		for (int n = 0; n < 16; n++)
		begin
			lf = nxt(lf);
			w[n] = lf;
			wr({2'h1, 4'(n), 2'h0}, {16'h0, lf});
		end
		for (int n = 0; n < 16; n++)
			chkw(4'(n), w[n]);
		for (int i = 0; i < 6; i++)
		begin
			lf = nxt(lf);
			pr = {16'h0, lf[15:12], 3'h0, lf[8], 4'h0, lf[3:0]};
			wr(8'h08, pr);
			lf = nxt(lf);
			{br, dr, sr} = lf[11:0];
			cmd = 32'h0;
			cmd[`CAD_CMD_OP] = 4'(i % 3);
			cmd[`CAD_CMD_CIN] = i > 2;
			cmd[`CAD_CMD_SREG] = sr;
			cmd[`CAD_CMD_DREG] = dr;
			cmd[`CAD_CMD_BREG] = br;
			lf = nxt(lf);
			cmd2 = {22'h0, lf[9:0]};
			a = (i % 3 == 2) ? w[dr] : w[br];
			b = (i % 3 == 0) ? w[sr] : (i % 3 == 1) ? {11'h0, lf[4:0]}
				: {6'h0, lf[9:0]};
			q = fadd(a, b, i > 2 && pr[0], i > 2 ? pr[1] : 1'b1);
			run(cmd2, cmd);
			w[dr] = q[31:16];
			chk(st, (pr & ~32'h10f) | {23'h0, q[8:0]});
			chkw(dr, w[dr]);
		end
		wr(8'h4c, 32'h8001);
		wr(8'h08, 32'hf104);
		run(32'h0, 32'h0008_6000 | `CAD_OP_ASR_W);
		chk(st, 32'h0000f109);
		chkw(4'h4, 16'hc000);
		lf = nxt(lf);
		wr(8'h08, 32'h0105);
		run({27'h0, lf[4:0]}, 32'h006a_0000 | `CAD_OP_ASR_L5);
		chk(st, 32'h0000010d);
		chkw(4'h5, $signed(16'h8001) >>> lf[4:0]);
		wr(8'h20, 32'h10);
		wr(8'h24, 32'h1234);
		wr(8'h48, 32'h10);
		run(32'h0, 32'h006c_4100 | `CAD_OP_ADD_W);
		chkw(4'h6, 16'h9235);
		chkw(4'h2, 16'h0012);
		run(32'h10, 32'h20 | `CAD_OP_ADD_F);
		chkw(4'h0, w[0] + 16'h1234);
		setw(4'hd, 16'h0020);
		setw(4'he, 16'h0010);
		wr(8'h20, 32'h30);
		wr(8'h24, 32'h7fff);
		run(32'h00c, 32'h01c1_a349);
		chk({28'h0, st[15:12]}, 32'h4);
		rd(8'h18, q);
		chk(q, 32'hfff0_0000);
		rd(8'h1c, q);
		chk(q, 32'h07);
		for (int n = 4; n < 8; n++)
		begin
			lf = nxt(lf);
			setw(4'(n), lf);
		end
		setw(4'h8, 16'h0020);
		setw(4'ha, 16'h0030);
		wr(8'h20, 32'h20);
		wr(8'h24, 32'h5a5a);
		lf = nxt(lf);
		p = lf[2:0] % 3'h6;
		pt = pair_tab[8 * (5 - p) +: 8];
		ep = $signed(w[pt[7:4]]) * $signed(w[pt[3:0]]);
		wr(8'h04, {5'h0, lf[9:8], 5'h15, lf[7:6], 5'h0d, p, 10'h0});
		wr(8'h00, 32'ha);
		wr(8'h00, 32'ha);
		do rd(8'h08, st); while (st[16] !== 1'b0);
		chk({16'h0, st[18], 11'h0, st[15:12]}, 32'h8004);
		w[{2'h1, lf[7:6]}] = 16'h5a5a;
		w[{2'h1, lf[9:8]}] = 16'h7fff;
		rd(8'h10, q);
		chk(q, ep[31:0]);
		rd(8'h14, q);
		chk(q, {24'h0, ep[39:32]});
		for (int n = 4; n < 8; n++)
			chkw(4'(n), w[n]);
		chkw(4'h8, 16'h0026);
		chkw(4'ha, 16'h002a);
		setw(4'h9, 16'h0010);
		setw(4'hb, 16'h0020);
		setw(4'hc, 16'h0010);
		lf = nxt(lf);
		ep = $signed(w[{2'h1, lf[1:0]}]) * $signed(w[{2'h1, lf[1:0]}]);
		ep = ep + 40'h07_fff0_0000;
		run({5'h0, 2'h3, 3'h0, 2'h3, 2'h2, 3'h0, 2'h3, 1'b0, lf[1:0], 10'h0},
			32'h4b);
		rd(8'h18, q);
		chk(q, ep[31:0]);
		rd(8'h1c, q);
		chk(q, {24'h0, ep[39:32]});
		chkw(4'h6, 16'h5a5a);
		chkw(4'h7, 16'h7fff);
		chkw(4'h9, 16'h0010);
		run(32'h0, 32'h01c0_800c);
		chkw(4'h0, $signed(w[4]) / $signed(w[14]));
		chkw(4'h1, $signed(w[4]) % $signed(w[14]));
		wrb(8'h7c, 32'h0000_ffff, 4'h1);
		w[15][7:0] = 8'hff;
		chkw(4'hf, w[15]);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h80 | `CAD_OP_ADD_WSO);
		rd(8'h08, st);
		chk({31'h0, st[17]}, 32'h1);
		tally_and_finish;
	end
endmodule // tb_top
